// *** common/mbst_params.svh ***
// Purpose: Constants for the modem self-test sequencer.
// Assumes: 40 MHz system clock.
// Notes: Lamp and relay times are kept in ms and converted to cycles in the module; settle, lock timeout and loop-back are given in cycles.
`ifndef MBST_PARAMS_SVH
`define MBST_PARAMS_SVH
`define MBST_CLK_HZ 40000000
`define MBST_LAMP_MS 4000
`define MBST_RELAY_MS 1000
`define MBST_SETTLE_CYC 4000
`define MBST_LOCK_TO_CYC 40000
`define MBST_LB_CYC 80000
`define MBST_SEL_LAMP 4'h1
`define MBST_SEL_UNIT 4'h2
`define MBST_SEL_BOTH 4'h3
`define MBST_SEL_ABORT 4'h0
`define MBST_F1_KHZ 17'h0c2ec
`define MBST_F2_KHZ 17'h15ff4
`define MBST_R1_BPS 23'h4b12c0
`define MBST_R2_BPS 23'h000960
`endif

// *** common/mbst_pkg.sv ***
// Purpose: Types shared by the self-test sequencer and its bench.
// Assumes: Constants come from mbst_params.svh.
// Notes: States are Gray coded along the normal test path.
package mbst_pkg;
   typedef enum logic [3:0] {
      MBST_IDLE = 4'h0, MBST_LAMP = 4'h1, MBST_RLY_A = 4'h3, MBST_RLY_B = 4'h2,
      MBST_ALM1 = 4'h6, MBST_ALM2 = 4'h7, MBST_FRQ1 = 4'h5, MBST_FRQ2 = 4'h4,
      MBST_LB1 = 4'hc, MBST_LB2 = 4'hd, MBST_DONE = 4'hf
   } mbst_state_t;
   typedef enum logic [1:0] {MBST_CR_NONE = 2'h0, MBST_CR_3_4 = 2'h1, MBST_CR_1_2 = 2'h2} mbst_code_t;
   // Settings pushed to the modulator, demodulator and alarm logic.
   typedef struct packed {
      logic alarm_force;
      logic alarm_clear;
      logic [16:0] freq_khz;
      logic [22:0] rate_bps;
      logic qpsk;
      mbst_code_t code;
      logic if_loop;
   } mbst_cfg_t;
   // Panel, relay and receive-path drive.
   typedef struct packed {
      logic lamps;
      logic relay_a;
      logic relay_b;
      logic rx_isolate;
   } mbst_drive_t;
   // Monitored status from the modem.
   typedef struct packed {
      logic [7:0] alarms;
      logic volt_ok;
      logic loop_volt_ok;
      logic lock;
      logic ebno_ok;
      logic level_ok;
      logic offset_ok;
      logic bert_err;
      logic bert_sync;
   } mbst_mon_t;
endpackage

// *** hdl/mbst_seq.sv ***
// Purpose: Built-in self-test sequencer: lamp test, relay test, alarm, frequency limit and loop-back tests.
// Assumes: Keypad strobes and monitor flags come from logic on i_clk.
// Notes: A failed step does not stop the run; the verdict is given at the end.
`include "mbst_params.svh"
// What this block does
// - Selection 1 runs lamp test, 2 unit tests, 3 lamp then unit tests.
// - Entering 0 then confirm aborts a running self test.
// - Receive IF path is isolated from the station input throughout self test.
// - Lamp test lights every panel indicator and the backlight.
// - Lamp test lasts 4 seconds with both alarm relays off.
// - Relay A alone on 1 second, then relay B on 1 second.
// - Alarm pass one forces failures; any missing alarm fails the test.
// - Alarm pass two clears alarms; any remaining alarm fails the test.
// - Frequency step one tunes to 49.90 MHz and checks loop voltages.
// - Every sampled voltage out of range fails the frequency-limit test.
// - Frequency step two tunes to 90.10 MHz and rechecks all voltages.
// - Loop-back one: 4.92 Mbps, QPSK, rate 3/4, internal IF loop.
// - Loop-back two: 2.4 kbps, QPSK, rate 1/2, internal IF loop.
// - Loop-back passes only with timely lock and Eb/No, level, offset in limits.
// - Bit-error tester runs; any error or sync loss fails the loop-back.
module mbst_seq import mbst_pkg::*; #(
   parameter logic [27:0] LAMP_CYC = 28'((`MBST_CLK_HZ / 1000) * `MBST_LAMP_MS),
   parameter logic [27:0] RELAY_CYC = 28'((`MBST_CLK_HZ / 1000) * `MBST_RELAY_MS),
   parameter logic [27:0] SETTLE_CYC = 28'(`MBST_SETTLE_CYC),
   parameter logic [27:0] LOCK_TO_CYC = 28'(`MBST_LOCK_TO_CYC),
   parameter logic [27:0] LB_CYC = 28'(`MBST_LB_CYC)
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Operator keypad.
   input wire logic i_key_valid,
   input wire logic [3:0] i_key_digit,
   input wire logic i_key_enter,
   // Modem status.
   input wire mbst_mon_t i_mon,
   // Drive and configuration.
   output mbst_drive_t o_drive,
   output mbst_cfg_t o_cfg,
   // Verdict.
   output logic o_busy,
   output logic o_done,
   output logic o_pass
);
   mbst_state_t state, next_state;
   logic [27:0] cnt;
   logic [3:0] digit;
   logic digit_ok;
   logic units;
   logic failed;
   logic locked;
   mbst_cfg_t next_cfg;
   mbst_drive_t next_drive;

   // Keypad decode: a digit then confirm starts or aborts.
   wire sel_ok = digit_ok && digit >= `MBST_SEL_LAMP && digit <= `MBST_SEL_BOTH;
   wire start = i_key_enter && state == MBST_IDLE && sel_ok;
   wire abort = i_key_enter && state != MBST_IDLE && state != MBST_DONE
                && digit_ok && digit == `MBST_SEL_ABORT;
   wire is_lb = state == MBST_LB1 || state == MBST_LB2;
   wire chk = cnt == SETTLE_CYC - 28'h1;
   wire lamp_end = cnt == LAMP_CYC - 28'h1;
   wire relay_end = cnt == RELAY_CYC - 28'h1;
   wire lb_end = cnt == LB_CYC - 28'h1;

   // Failure terms for the alarm, frequency and loop-back steps; any of them marks the run failed.
   wire fail_alm1 = state == MBST_ALM1 && chk && !(&i_mon.alarms);
   wire fail_alm2 = state == MBST_ALM2 && chk && (|i_mon.alarms);
   wire fail_frq = (state == MBST_FRQ1 || state == MBST_FRQ2) && chk
                   && !(i_mon.volt_ok && i_mon.loop_volt_ok);
   wire fail_lock = is_lb && !locked && !i_mon.lock && cnt == LOCK_TO_CYC - 28'h1;
   wire fail_bert = is_lb && locked && (i_mon.bert_err || !i_mon.bert_sync);
   wire fail_qual = is_lb && lb_end && !(i_mon.ebno_ok && i_mon.level_ok && i_mon.offset_ok);
   wire fail_now = fail_alm1 || fail_alm2 || fail_frq || fail_lock || fail_bert || fail_qual;

   // Step sequencing; abort overrides every step.
   always_comb begin
      next_state = state;
      if (abort) begin
         next_state = MBST_DONE;
      end else begin
         case (state)
            MBST_IDLE: if (start) next_state = (digit == `MBST_SEL_UNIT) ? MBST_RLY_A : MBST_LAMP;
            MBST_LAMP: if (lamp_end) next_state = units ? MBST_RLY_A : MBST_DONE;
            MBST_RLY_A: if (relay_end) next_state = MBST_RLY_B;
            MBST_RLY_B: if (relay_end) next_state = MBST_ALM1;
            MBST_ALM1: if (chk) next_state = MBST_ALM2;
            MBST_ALM2: if (chk) next_state = MBST_FRQ1;
            MBST_FRQ1: if (chk) next_state = MBST_FRQ2;
            MBST_FRQ2: if (chk) next_state = MBST_LB1;
            MBST_LB1: if (lb_end) next_state = MBST_LB2;
            MBST_LB2: if (lb_end) next_state = MBST_DONE;
            MBST_DONE: next_state = MBST_IDLE;
            default: next_state = MBST_IDLE;
         endcase
      end
   end

   // Outputs are computed from the next state so they line up with the state register.
   always_comb begin
      next_cfg = '0;
      next_drive = '0;
      next_drive.rx_isolate = next_state != MBST_IDLE && next_state != MBST_DONE;
      case (next_state)
         MBST_LAMP: next_drive.lamps = 1'b1;
         MBST_RLY_A: next_drive.relay_a = 1'b1;
         MBST_RLY_B: next_drive.relay_b = 1'b1;
         MBST_ALM1: next_cfg.alarm_force = 1'b1;
         MBST_ALM2: next_cfg.alarm_clear = 1'b1;
         MBST_FRQ1: next_cfg.freq_khz = `MBST_F1_KHZ;
         MBST_FRQ2: next_cfg.freq_khz = `MBST_F2_KHZ;
         MBST_LB1: begin
            next_cfg.rate_bps = `MBST_R1_BPS;
            next_cfg.qpsk = 1'b1;
            next_cfg.code = MBST_CR_3_4;
            next_cfg.if_loop = 1'b1;
         end
         MBST_LB2: begin
            next_cfg.rate_bps = `MBST_R2_BPS;
            next_cfg.qpsk = 1'b1;
            next_cfg.code = MBST_CR_1_2;
            next_cfg.if_loop = 1'b1;
         end
         default: next_cfg = '0;
      endcase
   end

   // State, step timer and registered outputs.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= MBST_IDLE;
         cnt <= 28'h0;
         o_cfg <= '0;
         o_drive <= '0;
      end else begin
         state <= next_state;
         cnt <= (next_state != state) ? 28'h0 : cnt + 28'h1;
         o_cfg <= next_cfg;
         o_drive <= next_drive;
      end
   end

   // Last keypad digit; confirm consumes it so a stale digit cannot restart a run.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         digit <= 4'h0;
         digit_ok <= 1'b0;
      end else if (i_key_valid) begin
         digit <= i_key_digit;
         digit_ok <= 1'b1;
      end else if (i_key_enter) begin
         digit_ok <= 1'b0;
      end
   end

   // Run bookkeeping: selection, sticky failure, lock seen in the current loop-back.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         units <= 1'b0;
         failed <= 1'b0;
         locked <= 1'b0;
      end else begin
         if (start) units <= digit != `MBST_SEL_LAMP;
         if (start) failed <= 1'b0;
         else if (fail_now || abort) failed <= 1'b1;
         locked <= is_lb && next_state == state && (locked || i_mon.lock);
      end
   end

   // Verdict is registered on the cycle after the run ends.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_done <= 1'b0;
         o_pass <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         o_done <= state == MBST_DONE;
         o_busy <= next_state != MBST_IDLE && next_state != MBST_DONE;
         if (state == MBST_DONE) o_pass <= !failed;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   sel_route_a: assert property (start |=> ($past(digit) == `MBST_SEL_UNIT) == (state == MBST_RLY_A))
      else $error("selection routed to wrong first step");
   abort_done_a: assert property (abort |=> state == MBST_DONE ##1 o_done && !o_pass)
      else $error("abort did not end the run as failed");
   rx_isolate_a: assert property (!(state inside {MBST_IDLE, MBST_DONE}) |-> o_drive.rx_isolate)
      else $error("receive path not isolated during test");
   lamp_drive_a: assert property (state == MBST_LAMP |-> o_drive.lamps)
      else $error("lamps not driven in lamp test");
   lamp_relay_a: assert property (state == MBST_LAMP |-> !o_drive.relay_a && !o_drive.relay_b
      && cnt < LAMP_CYC)
      else $error("relay on or overlong lamp test");
   relay_order_a: assert property (state == MBST_RLY_A && relay_end && !abort |=> state == MBST_RLY_B
      && o_drive.relay_b && !o_drive.relay_a)
      else $error("relay B did not follow relay A");
   alarm_one_a: assert property (fail_alm1 |=> failed)
      else $error("missing alarm not recorded");
   alarm_two_a: assert property (state == MBST_ALM2 |-> o_cfg.alarm_clear && !o_cfg.alarm_force)
      else $error("alarm clear pass misconfigured");
   freq_one_a: assert property (state == MBST_FRQ1 |-> o_cfg.freq_khz == `MBST_F1_KHZ)
      else $error("first frequency step wrong");
   volt_fail_a: assert property ($rose(fail_frq) |=> failed)
      else $error("voltage fault not recorded");
   freq_two_a: assert property (state == MBST_FRQ2 |-> o_cfg.freq_khz == `MBST_F2_KHZ)
      else $error("second frequency step wrong");
   loop_one_a: assert property (state == MBST_LB1 |-> o_cfg.if_loop && o_cfg.code == MBST_CR_3_4
      && o_cfg.rate_bps == `MBST_R1_BPS)
      else $error("first loop-back misconfigured");
   loop_two_a: assert property (state == MBST_LB2 |-> o_cfg.if_loop && o_cfg.code == MBST_CR_1_2
      && o_cfg.rate_bps == `MBST_R2_BPS)
      else $error("second loop-back misconfigured");
   lock_to_a: assert property (is_lb && !i_mon.lock && !locked && cnt == LOCK_TO_CYC - 28'h1 |=> failed)
      else $error("lock timeout not recorded");
   bert_fail_a: assert property (fail_bert |=> failed)
      else $error("bit-error fault not recorded");
   verdict_a: assert property (state == MBST_DONE |=> o_done && o_pass == !$past(failed))
      else $error("verdict does not match run result");

   lamp_only_c: cover property (state == MBST_LAMP && lamp_end && !units ##1 state == MBST_DONE ##1 o_done && o_pass);
   unit_run_c: cover property (state == MBST_LB2 ##1 state == MBST_DONE);
   abort_c: cover property (abort && state == MBST_RLY_A);
   bert_c: cover property (fail_bert);
endmodule

// *** test/mbst_panel_model.sv ***
// Purpose: Operator keypad and modem status model facing the self-test sequencer.
// Assumes: Sequencer settings arrive on the same clock; status answers within the same cycle.
// Notes: Fault codes 1..9 break one monitored condition each; 0 is a healthy modem.
module mbst_panel_model import mbst_pkg::*; (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Sequencer settings and fault choice from the bench.
   input wire mbst_cfg_t i_cfg,
   input wire logic [3:0] i_fault,
   // Keypad and status towards the sequencer.
   output logic o_key_valid,
   output logic [3:0] o_key_digit,
   output logic o_key_enter,
   output mbst_mon_t o_mon
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] lock_cnt;
   logic lock_now;

   // Keys rest released from time zero.
   initial begin
      o_key_valid = 1'b0;
      o_key_digit = 4'h0;
      o_key_enter = 1'b0;
   end

   // One digit strobe then the confirm key; the digit lines are scrambled afterwards so a stale value cannot help.
   task automatic press(input logic [3:0] d);
      @(posedge i_clk);
      o_key_valid <= 1'b1;
      o_key_digit <= d;
      @(posedge i_clk);
      o_key_valid <= 1'b0;
      o_key_digit <= ~d;
      o_key_enter <= 1'b1;
      @(posedge i_clk);
      o_key_enter <= 1'b0;
   endtask

   // Lock takes a few cycles of internal loop; fault 3 makes it too slow for the timeout.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lock_cnt <= 5'h00;
      end else if (!i_cfg.if_loop) begin
         lock_cnt <= 5'h00;
      end else if (lock_cnt != 5'h1f) begin
         lock_cnt <= lock_cnt + 5'h01;
      end
   end
   assign lock_now = i_cfg.if_loop && (lock_cnt >= ((i_fault == 4'h3) ? 5'h14 : 5'h02));

   // Status follows the forced or cleared alarm settings unless fault 1 or 5 is chosen.
   always_comb begin
      o_mon = '0;
      o_mon.alarms = i_cfg.alarm_force ? 8'hff : 8'h00;
      if (i_fault == 4'h1) o_mon.alarms[0] = 1'b1;
      if (i_fault == 4'h5) o_mon.alarms[7] = 1'b0;
      o_mon.volt_ok = (i_fault != 4'h4);
      o_mon.loop_volt_ok = (i_fault != 4'h6);
      o_mon.lock = lock_now;
      // Quality faults are held for the whole run, so only the loop-back end check can catch them.
      o_mon.ebno_ok = (i_fault != 4'h7);
      o_mon.level_ok = (i_fault != 4'h8);
      o_mon.offset_ok = (i_fault != 4'h9);
      o_mon.bert_err = (i_fault == 4'h2) && lock_now;
      o_mon.bert_sync = lock_now;
   end
endmodule

// *** test/modem_builtin_self_test_sequencer_tb.sv ***
// Purpose: Self-checking bench for the self-test sequencer.
// Assumes: Shortened counts: lamp 40, relay 20, settle 8, lock timeout 10, loop-back 30 cycles.
// Notes: Each step is checked on every cycle; start latency is waited for under a bound.
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module modem_builtin_self_test_sequencer_tb import mbst_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LAMP = 40, RLY = 20, SET = 8, LB = 30;
   localparam mbst_cfg_t M_ALM = 46'h300000000000, M_FRQ = 46'h0ffff8000000, M_LB = 46'h000007ffffff;
   logic i_clk, i_arst_n = 1'b0, key_valid, key_enter, busy, done, pass;
   logic [3:0] fault = 4'h0;
   logic [3:0] key_digit;
   mbst_mon_t mon;
   mbst_drive_t drive;
   mbst_cfg_t cfg;
   int bad_count = 0, checks_done = 0;

   mbst_seq #(.LAMP_CYC(28'h28), .RELAY_CYC(28'h14), .SETTLE_CYC(28'h8), .LOCK_TO_CYC(28'ha), .LB_CYC(28'h1e)) u_dut (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_key_valid(key_valid), .i_key_digit(key_digit),
      .i_key_enter(key_enter), .i_mon(mon), .o_drive(drive), .o_cfg(cfg), .o_busy(busy), .o_done(done), .o_pass(pass));
   mbst_panel_model u_mdl (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cfg(cfg), .i_fault(fault),
      .o_key_valid(key_valid), .o_key_digit(key_digit), .o_key_enter(key_enter), .o_mon(mon));

   // Free-running 40 MHz clock.
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   function automatic mbst_cfg_t mk(logic f, logic c, logic [16:0] fq, logic [22:0] r, mbst_code_t cd);
      mk = '{f, c, fq, r, cd != MBST_CR_NONE, cd, cd != MBST_CR_NONE};
   endfunction

   // Masks keep each step to the fields it owns, since the rest are not pinned down.
   task automatic hold(input int n, input mbst_drive_t d, input mbst_cfg_t c, input mbst_cfg_t m);
      repeat (n) begin
         `CHK(drive, d)
         `CHK(cfg & m, c & m)
         `CHK(busy, 1'b1)
         @(posedge i_clk) #1;
      end
   endtask

   task automatic start(input logic [3:0] d);
      int k;
      u_mdl.press(d);
      #1;
      for (k = 0; k < 4 && busy !== 1'b1; k++) @(posedge i_clk) #1;
   endtask

   task automatic finish(input logic exp);
      `CHK(busy, 1'b0)
      `CHK(drive, 4'h0)
      @(posedge i_clk) #1;
      `CHK(done, 1'b1)
      `CHK(pass, exp)
      @(posedge i_clk) #1;
   endtask

   task automatic unit_steps();
      hold(RLY, 4'b0101, '0, '1);
      hold(RLY, 4'b0011, '0, '1);
      hold(SET, 4'b0001, mk(1'b1, 1'b0, 17'h0, 23'h0, MBST_CR_NONE), M_ALM);
      hold(SET, 4'b0001, mk(1'b0, 1'b1, 17'h0, 23'h0, MBST_CR_NONE), M_ALM);
      hold(SET, 4'b0001, mk(1'b0, 1'b0, 17'h0c2ec, 23'h0, MBST_CR_NONE), M_FRQ);
      hold(SET, 4'b0001, mk(1'b0, 1'b0, 17'h15ff4, 23'h0, MBST_CR_NONE), M_FRQ);
      hold(LB, 4'b0001, mk(1'b0, 1'b0, 17'h0, 23'h4b12c0, MBST_CR_3_4), M_LB);
      hold(LB, 4'b0001, mk(1'b0, 1'b0, 17'h0, 23'h000960, MBST_CR_1_2), M_LB);
   endtask

   task automatic sc_modes();
      start(4'h1);
      hold(LAMP, 4'b1001, '0, '1);
      finish(1'b1);
      start(4'h2);
      unit_steps();
      finish(1'b1);
      start(4'h3);
      hold(LAMP, 4'b1001, '0, '1);
      unit_steps();
      finish(1'b1);
   endtask

   // Abort in the lamp test and in the unit tests; the verdict must be a fail.
   task automatic sc_abort();
      for (int s = 1; s <= 2; s++) begin
         start(4'(s));
         repeat (5) @(posedge i_clk);
         u_mdl.press(4'h0);
         #1;
         for (int k = 0; k < 3 && busy !== 1'b0; k++) @(posedge i_clk) #1;
         finish(1'b0);
      end
   endtask

   // Each fault breaks one check; the run still completes its full path.
   task automatic sc_faults();
      for (int f = 1; f <= 9; f++) begin
         @(posedge i_clk) fault <= 4'(f);
         start(4'h2);
         unit_steps();
         finish(1'b0);
      end
      @(posedge i_clk) fault <= 4'h0;
   endtask

   // An unknown digit and an idle abort must leave the sequencer quiet.
   task automatic sc_refuse();
      u_mdl.press(4'h5);
      u_mdl.press(4'h0);
      repeat (6) begin
         @(posedge i_clk) #1;
         `CHK({busy, done}, 2'b00)
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence after two cycles of reset.
   initial begin
      repeat (2) @(posedge i_clk);
      i_arst_n <= 1'b1;
      sc_refuse();
      sc_modes();
      sc_abort();
      sc_faults();
      report_and_stop();
   end

   // The whole run needs about 1650 cycles; a hang stops here.
   initial begin
      repeat (5000) @(posedge i_clk);
      bad_count++;
      report_and_stop();
   end
endmodule
